// >>> core/frc_consts.vh
// Constants for the floppy rate control and result status block.
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH
`define FRC_ADDR_RATE        16'h03F7
`define FRC_RATE_RESET       2'h2
`define FRC_RATE_LO          1
`define FRC_RATE_HI          0
`define FRC_PRECOMP_BIT      2
`define FRC_MODE_AT          2'h0
`define FRC_MODE_INV         2'h1
`define FRC_MODE_ALT         2'h2
`define FRC_IC_NORMAL        2'h0
`define FRC_IC_ABNORMAL      2'h1
`define FRC_IC_INVALID       2'h2
`define FRC_IC_POLLING       2'h3
`define FRC_RECAL_STEPS      7'h50
`define FRC_INDEX_LIMIT      2'h2
`define FRC_RATE_250K        2'h2
`define FRC_RATE_300K        2'h1
`endif

// >>> core/frc_rate_status.v
// Rate control register, digital input read-back and result status bytes 0 and 1.
`timescale 1ns/1ps
`include "frc_consts.vh"
// Notes on behaviour
// (RULE1) Write-only register at 3F7; bits 1:0 pick data rate, reset to binary 10.
// (RULE2) Host writes zeros into reserved upper bits of the rate register.
// (RULE3) Alternate mode bit 2 stores precomp-off flag, with no other effect.
// (RULE4) In alternate mode the stored flag reads back on status bit 2.
// (RULE5) Precomp-off flag survives both software resets.
// (RULE6) Density pin goes high on hardware reset, ignores software resets.
// (RULE7) Result phase presents status bytes describing the finished command.
// (RULE8) Status 0 bits 7:6 give the termination code.
// (RULE9) Status 0 bit 5 marks a completed seek, relative seek or recalibrate.
// (RULE10) Status 0 bit 4: no track zero after 80 steps, or stepped past zero.
// (RULE11) Status 0 bit 3 is zero, bit 2 head, bits 1:0 drive.
// (RULE12) Status 1 bit 7: past last sector, or data command ended without strobe.
// (RULE13) Status 1 bits 6 and 3 always read zero.
// (RULE14) Status 1 bit 5: CRC error in ID or data field.
// (RULE15) Status 1 bit 4: transfer not serviced in time.
// (RULE16) Status 1 bit 2: sector not found, bad ID read, or wrong sequence.
// (RULE17) Status 1 bit 1: write protect high during a write or format.
// (RULE18) Status 1 bit 0: no ID mark after two index pulses, or no data mark.
// (RULE19) Reads at 3F7 return the read-only digital input register.
// (RULE20) Hardware reset selects 250 Kbps; software resets keep the rate.
// (RULE21) Written rate applies onward and shares the setting with the rate status write.
module frc_rate_status (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [15:0] io_addr,
    input  wire        io_write,
    input  wire        io_read,
    input  wire [7:0]  io_wdata,
    output reg  [7:0]  io_rdata,
    output wire        io_hit,
    input  wire [1:0]  reg_mode,
    input  wire        rate_status_write,
    input  wire [1:0]  rate_status_value,
    input  wire        soft_reset,
    input  wire        dma_enable_bit,
    input  wire        disk_change_pin,
    output wire [1:0]  data_rate,
    output wire        precomp_off_flag,
    output reg         density_pin_level,
    input  wire        cmd_start,
    input  wire        cmd_end,
    input  wire [1:0]  end_code,
    input  wire        seek_done,
    input  wire        recal_cmd,
    input  wire        step_pulse,
    input  wire        rel_seek_past_zero,
    input  wire        head_sel,
    input  wire [1:0]  drive_index,
    input  wire        track_zero_input,
    input  wire        rotation_pulse_input,
    input  wire        write_protect_input,
    input  wire        write_cmd,
    input  wire        id_search,
    input  wire        id_mark_found,
    input  wire        data_mark_missing,
    input  wire        past_last_sector,
    input  wire        data_cmd_no_strobe,
    input  wire        crc_fault,
    input  wire        service_late,
    input  wire        sector_missing,
    output reg  [7:0]  result_status_0,
    output reg  [7:0]  result_status_1
);

    reg [1:0] rate_sel;
    reg       precomp;
    reg [1:0] track_zero_input_sync;
    reg [1:0] wp_sync;
    reg [1:0] idx_sync;
    reg [1:0] dchg_sync;
    reg       idx_prev;
    reg [6:0] recal_steps;
    reg [1:0] index_seen;
    reg       homing_fault;
    reg       position_complete;
    reg       protected_write_fault;
    reg       id_sync_absent;
    reg       end_of_track;
    reg       crc_seen;
    reg       late_seen;
    reg       missing_seen;
    reg [1:0] next_rate_sel;
    reg       next_precomp;
    reg       next_density_pin;
    reg [6:0] next_recal_steps;
    reg [1:0] next_index_seen;
    reg       next_homing_fault;
    reg       next_position_complete;
    reg       next_protected_write_fault;
    reg       next_id_sync_absent;
    reg       next_end_of_track;
    reg       next_crc_seen;
    reg       next_late_seen;
    reg       next_missing_seen;

    wire rate_hit = (io_addr == `FRC_ADDR_RATE);
    wire rate_wr  = io_write && rate_hit;
    wire idx_rise = idx_sync[1] && !idx_prev;
    wire capture_clear = cmd_start || soft_reset;

    assign io_hit           = rate_hit && (io_write || io_read);
    assign data_rate        = rate_sel;
    assign precomp_off_flag = precomp;

    // Fast rates drive density high in the default mode and low in the two others.
    function dens_level;
        input [1:0] rate;
        input [1:0] mode;
        reg         slow;
        begin
            slow = (rate == `FRC_RATE_250K) || (rate == `FRC_RATE_300K);
            dens_level = (mode == `FRC_MODE_AT) ? !slow : slow;
        end
    endfunction

    // A fresh event beats a clear in the same cycle, so no event is lost at a command edge.
    function capture;
        input old;
        input clear;
        input hit;
        begin
            capture = (old && !clear) || hit;
        end
    endfunction

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            track_zero_input_sync <= 2'h0;
            wp_sync   <= 2'h0;
            idx_sync  <= 2'h0;
            dchg_sync <= 2'h0;
            idx_prev  <= 1'b0;
        end else begin
            track_zero_input_sync <= {track_zero_input_sync[0], track_zero_input};
            wp_sync   <= {wp_sync[0], write_protect_input};
            idx_sync  <= {idx_sync[0], rotation_pulse_input};
            dchg_sync <= {dchg_sync[0], disk_change_pin};
            idx_prev  <= idx_sync[1];
        end
    end

    // An I/O write wins over a rate status write that falls in the same cycle.
    always @* begin
        next_rate_sel    = rate_sel;
        next_precomp     = precomp;
        next_density_pin = density_pin_level;
        // (RULE21) shared rate setting
        if (rate_wr) begin
            next_rate_sel = {io_wdata[`FRC_RATE_LO], io_wdata[`FRC_RATE_HI]};
        end else if (rate_status_write) begin
            next_rate_sel = rate_status_value;
        end
        if (rate_wr || rate_status_write) begin
            next_density_pin = dens_level(next_rate_sel, reg_mode);
        end
        // (RULE3) (RULE5) store flag only
        if (rate_wr && reg_mode == `FRC_MODE_ALT) begin
            next_precomp = io_wdata[`FRC_PRECOMP_BIT];
        end
    end

    // Only the hardware reset touches rate, flag and density pin.
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            // (RULE1) (RULE20) reset rate
            rate_sel          <= `FRC_RATE_RESET;
            precomp           <= 1'b0;
            // (RULE6) density high
            density_pin_level <= 1'b1;
        end else begin
            rate_sel          <= next_rate_sel;
            precomp           <= next_precomp;
            density_pin_level <= next_density_pin;
        end
    end

    // (RULE19) digital input read-back
    always @* begin
        case (reg_mode)
            `FRC_MODE_INV: io_rdata = {!dchg_sync[1], 4'hF, rate_sel,
                                       !dens_level(rate_sel, `FRC_MODE_AT)};
            // (RULE4) flag on bit 2
            `FRC_MODE_ALT: io_rdata = {!dchg_sync[1], 3'h0, dma_enable_bit,
                                       precomp, rate_sel};
            default:       io_rdata = {!dchg_sync[1], 7'h00};
        endcase
        if (!(io_read && rate_hit)) begin
            io_rdata = 8'h00;
        end
    end

    // Counters restart on command start and software reset; they count nothing then.
    always @* begin
        next_recal_steps = recal_steps;
        next_index_seen  = index_seen;
        if (capture_clear) begin
            next_recal_steps = 7'h00;
            next_index_seen  = 2'h0;
        end else begin
            // (RULE10) homing step limit
            if (recal_cmd && step_pulse && !track_zero_input_sync[1] &&
                recal_steps != `FRC_RECAL_STEPS) begin
                next_recal_steps = recal_steps + 7'h01;
            end
            // (RULE18) two index pulses
            if (id_search && id_mark_found) begin
                next_index_seen = 2'h0;
            end else if (id_search && idx_rise && index_seen != `FRC_INDEX_LIMIT) begin
                next_index_seen = index_seen + 2'h1;
            end
        end
    end

    // Captured events; each flag holds until the next clear.
    always @* begin
        // (RULE9) seek end
        next_position_complete = capture(position_complete, capture_clear, seek_done);
        // (RULE10) homing fault
        next_homing_fault = capture(homing_fault, capture_clear,
            (recal_cmd && !track_zero_input_sync[1] && recal_steps == `FRC_RECAL_STEPS)
            || rel_seek_past_zero);
        // (RULE17) write protect fault
        next_protected_write_fault = capture(protected_write_fault, capture_clear,
                                             write_cmd && wp_sync[1]);
        // (RULE18) missing address mark
        next_id_sync_absent = capture(id_sync_absent, capture_clear,
            (id_search && index_seen == `FRC_INDEX_LIMIT) || data_mark_missing);
        // (RULE12) end of track
        next_end_of_track = capture(end_of_track, capture_clear,
                                    past_last_sector || data_cmd_no_strobe);
        // (RULE14) crc fault
        next_crc_seen = capture(crc_seen, capture_clear, crc_fault);
        // (RULE15) service late
        next_late_seen = capture(late_seen, capture_clear, service_late);
        // (RULE16) no data
        next_missing_seen = capture(missing_seen, capture_clear, sector_missing);
    end

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            recal_steps           <= 7'h00;
            index_seen            <= 2'h0;
            homing_fault          <= 1'b0;
            position_complete     <= 1'b0;
            protected_write_fault <= 1'b0;
            id_sync_absent        <= 1'b0;
            end_of_track          <= 1'b0;
            crc_seen              <= 1'b0;
            late_seen             <= 1'b0;
            missing_seen          <= 1'b0;
        end else begin
            recal_steps           <= next_recal_steps;
            index_seen            <= next_index_seen;
            homing_fault          <= next_homing_fault;
            position_complete     <= next_position_complete;
            protected_write_fault <= next_protected_write_fault;
            id_sync_absent        <= next_id_sync_absent;
            end_of_track          <= next_end_of_track;
            crc_seen              <= next_crc_seen;
            late_seen             <= next_late_seen;
            missing_seen          <= next_missing_seen;
        end
    end

    // (RULE7) latch result bytes at command end
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            result_status_0 <= 8'h00;
            result_status_1 <= 8'h00;
        end else if (cmd_end) begin
            // (RULE8) (RULE11) byte 0 layout
            result_status_0 <= {end_code, position_complete || seek_done,
                                homing_fault, 1'b0, head_sel, drive_index};
            // (RULE13) zero bits 6 and 3
            result_status_1 <= {end_of_track || past_last_sector || data_cmd_no_strobe,
                                1'b0, crc_seen || crc_fault, late_seen || service_late,
                                1'b0, missing_seen || sector_missing,
                                protected_write_fault, id_sync_absent};
        end
    end

endmodule // frc_rate_status

// >>> sim/frc_rate_status_properties.sv
// Concurrent checks on the rate control and result status ports.
`timescale 1ns/1ps
module frc_rate_status_properties (
    input wire        clk_sys,
    input wire        reset,
    input wire [15:0] io_addr,
    input wire        io_write,
    input wire        io_read,
    input wire [7:0]  io_wdata,
    input wire [7:0]  io_rdata,
    input wire        io_hit,
    input wire [1:0]  reg_mode,
    input wire        rate_status_write,
    input wire [1:0]  rate_status_value,
    input wire        soft_reset,
    input wire [1:0]  data_rate,
    input wire        precomp_off_flag,
    input wire        density_pin_level,
    input wire        cmd_end,
    input wire [1:0]  end_code,
    input wire        head_sel,
    input wire [1:0]  drive_index,
    input wire [7:0]  result_status_0,
    input wire [7:0]  result_status_1
);
    wire wr = io_write && io_addr == 16'h03F7;
    wire alt = reg_mode == 2'h2;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    rate_write_a: assert property (wr |=> data_rate == $past(io_wdata[1:0]))
        else $error("rate write lost");
    rate_share_a: assert property (rate_status_write && !wr |=>
        data_rate == $past(rate_status_value)) else $error("rate status write lost");
    rate_keep_a: assert property (!wr && !rate_status_write |=> $stable(data_rate))
        else $error("rate changed unasked");
    flag_store_a: assert property (wr && alt |=> precomp_off_flag == $past(io_wdata[2]))
        else $error("flag not stored");
    flag_keep_a: assert property (!(wr && alt) |=> $stable(precomp_off_flag))
        else $error("flag changed");
    read_back_a: assert property (io_read && io_addr == 16'h03F7 && alt |->
        io_rdata[6:0] == {3'h0, io_rdata[3], precomp_off_flag, data_rate}) else $error("bad read");
    density_soft_a: assert property (soft_reset && !wr && !rate_status_write |=>
        $stable(density_pin_level)) else $error("density moved");
    result_code_a: assert property (cmd_end |=> result_status_0[7:6] == $past(end_code) &&
        result_status_0[2:0] == {$past(head_sel), $past(drive_index)}) else $error("bad byte 0");
    result_zero_a: assert property (!result_status_0[3] && !result_status_1[6] &&
        !result_status_1[3]) else $error("unused bit set");
    addr_hit_a: assert property (io_hit == ((io_write || io_read) && io_addr == 16'h03F7))
        else $error("bad address decode");
    cover property (wr && alt);
    cover property (cmd_end && end_code == 2'h3);
    cover property (soft_reset);
endmodule // frc_rate_status_properties
bind frc_rate_status frc_rate_status_properties u_props (.*);

// >>> sim/frc_host.sv
// Host processor model issuing single-cycle register accesses.
`timescale 1ns/1ps
module frc_host (
    input  wire        clk_sys,
    input  wire [7:0]  io_rdata,
    output reg  [15:0] io_addr,
    output reg         io_write,
    output reg         io_read,
    output reg  [7:0]  io_wdata
);
    initial {io_addr, io_write, io_read, io_wdata} = 26'h0;
    // Called just after a rising edge; released address and data lines show inverted values, strobes go low.
    task access(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        begin
            io_addr = a;
            io_write = w;
            io_read = !w;
            io_wdata = d & 8'h07;
            @(posedge clk_sys);
            q = io_rdata;
            #1;
            {io_write, io_read} = 2'h0;
            io_addr = ~a;
            io_wdata = ~d;
        end
    endtask
endmodule // frc_host

// >>> sim/fdc_rate_control_and_result_status_bench.sv
// Self-checking bench for the rate control and result status block.
`timescale 1ns/1ps
module fdc_rate_control_and_result_status_bench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [1:0] reg_mode, rate_status_value, end_code, drive_index;
    logic rate_status_write, soft_reset, dma_enable_bit, disk_change_pin, cmd_start, cmd_end;
    logic recal_cmd, step_pulse, head_sel, id_search;
    logic [8:0] ev;
    logic [15:0] r;
    logic [7:0] q, e;
    wire [15:0] io_addr;
    wire io_write, io_read, io_hit, precomp_off_flag, density_pin_level;
    wire [7:0] io_wdata, io_rdata, result_status_0, result_status_1;
    wire [1:0] data_rate;
    int n_errors = 0;
    int checks = 0;
    // Row: mode nibble, written byte, then rate, flag and density expected.
    logic [15:0] rows [8] = '{16'h003D, 16'h0041, 16'h1015, 16'h103C,
                              16'h2057, 16'h2029, 16'h207E, 16'h006A};
    logic [15:0] evx [9] = '{16'h2000, 16'h1000, 16'h0080, 16'h0080, 16'h0020,
                             16'h0010, 16'h0004, 16'h0001, 16'h0002};
    always #20 clk_sys = ~clk_sys;
    frc_host u_host (.*);
    frc_rate_status u_dut (.*, .seek_done(ev[0]), .rel_seek_past_zero(ev[1]),
        .past_last_sector(ev[2]), .data_cmd_no_strobe(ev[3]), .crc_fault(ev[4]),
        .service_late(ev[5]), .sector_missing(ev[6]), .data_mark_missing(ev[7]),
        .write_protect_input(ev[8]), .write_cmd(ev[8]), .id_search(id_search),
        .id_mark_found(1'b0), .rotation_pulse_input(step_pulse), .track_zero_input(1'b0));
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, g, x);
        end
    endtask
    task cmd(input logic [8:0] evs, input int steps);
        cmd_start = 1'b1;
        tick(1);
        cmd_start = 1'b0;
        ev = evs;
        repeat (steps) begin
            step_pulse = 1'b1;
            tick(1);
            step_pulse = 1'b0;
            tick(1);
        end
        tick(4);
        ev = '0;
        cmd_end = 1'b1;
        tick(1);
        cmd_end = 1'b0;
        tick(1);
    endtask
    task test_done;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        {reg_mode, rate_status_value, end_code, drive_index, rate_status_write, soft_reset,
            dma_enable_bit, disk_change_pin, cmd_start, cmd_end, recal_cmd, step_pulse,
            head_sel, id_search, ev} = '0;
        tick(10);
        reset = 1'b0;
        chk({data_rate, precomp_off_flag, density_pin_level, result_status_0, result_status_1}, 20'h90000);
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            reg_mode = r[13:12];
            dma_enable_bit = i[0];
            disk_change_pin = i[1];
            u_host.access(1'b1, 16'h03F7, r[11:4], q);
            tick(3);
            u_host.access(1'b0, 16'h03F7, 8'h00, q);
            e = r[13:12] == 2'h0 ? {~i[1], 7'h00} : r[13:12] == 2'h1 ?
                {~i[1], 4'hF, r[3:2], r[0]} : {~i[1], 3'h0, i[0], r[1], r[3:2]};
            chk({data_rate, precomp_off_flag, density_pin_level}, r[3:0]);
            chk(q, e);
        end
        $display("rate rows done");
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        u_host.access(1'b1, 16'h03F5, 8'h01, q);
        tick(1);
        chk({data_rate, precomp_off_flag, density_pin_level}, 4'hA);
        {rate_status_value, rate_status_write} = 3'h7;
        tick(1);
        rate_status_write = 1'b0;
        tick(1);
        chk(data_rate, 2'h3);
        $display("soft reset and shared rate done");
        for (int c = 0; c < 4; c++) begin
            {end_code, head_sel, drive_index} = {c[1:0], c[0], ~c[1:0]};
            cmd('0, 0);
            chk(result_status_0, {c[1:0], 3'h0, c[0], ~c[1:0]});
        end
        {end_code, head_sel, drive_index} = '0;
        for (int i = 0; i < 9; i++) begin
            cmd(9'h1 << i, 0);
            chk({result_status_0, result_status_1}, evx[i]);
        end
        recal_cmd = 1'b1;
        cmd('0, 80);
        recal_cmd = 1'b0;
        chk(result_status_0, 8'h10);
        id_search = 1'b1;
        cmd('0, 2);
        id_search = 1'b0;
        chk(result_status_1, 8'h01);
        $display("result bytes done");
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        chk({data_rate, precomp_off_flag, density_pin_level}, 4'h9);
        chk({result_status_0, result_status_1}, 16'h0000);
        $display("hardware reset done");
        test_done;
    end
    initial begin
        #200000;
        n_errors++;
        test_done;
    end
endmodule // fdc_rate_control_and_result_status_bench
